// [pkg/pfg_pkg.sv]
// register map, field layout and constants of the post-divider frame pulse block
package pfg_pkg;

    // ============================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] PFG_IDX_S1_DIV_D = 8'h95;
    localparam logic [7:0] PFG_IDX_S2_DIV_A = 8'h98;
    localparam logic [7:0] PFG_IDX_ROUTE = 8'hB4;
    localparam logic [7:0] PFG_IDX_STATUS = 8'hC0;

    // ============================================================
    // reset values
    localparam logic [23:0] PFG_S1_DIV_D_RST = 24'h000032;
    localparam logic [23:0] PFG_S2_DIV_A_RST = 24'h000000;
    localparam logic [1:0] PFG_ROUTE_RST = 2'h0;

    // ============================================================
    // divider register fields
    localparam int PFG_MODE_HI = 23;
    localparam int PFG_MODE_LO = 20;
    localparam int PFG_TYPE_BIT = 19;
    localparam int PFG_POL_BIT = 18;
    localparam int PFG_SEL_HI = 17;
    localparam int PFG_SEL_LO = 16;
    localparam int PFG_PER_HI = 15;
    localparam int PFG_PER_LO = 0;
    localparam logic [3:0] PFG_FRAME_NIBBLE = 4'hF;
    localparam logic [23:0] PFG_MAX_RATIO = 24'hEFFFFF;
    localparam logic [23:0] PFG_MIN_RATIO = 24'h000002;

    // ============================================================
    // route and status register fields
    localparam int PFG_ROUTE_D_BIT = 0;
    localparam int PFG_ROUTE_A_BIT = 1;
    localparam int PFG_STAT_D_OUT_BIT = 0;
    localparam int PFG_STAT_A_OUT_BIT = 1;
    localparam int PFG_STAT_D_RSV_BIT = 2;
    localparam int PFG_STAT_A_RSV_BIT = 3;

    // ============================================================
    // related clock select: which code is reserved for each channel
    localparam logic [1:0] PFG_S1_RSV_SEL = 2'h3;
    localparam logic [1:0] PFG_S2_RSV_SEL = 2'h0;

    // ============================================================
    // bus answer
    localparam logic [31:0] PFG_UNMAPPED_DATA = 32'h00000000;

endpackage

// [rtl/pfg_postdivider_top.sv]
// post-divider clock and frame pulse generator with its register slave
`timescale 1ns/1ps

// ============================================================
// one post-divider channel
module pfg_channel
    import pfg_pkg::*;
#(
    parameter logic [1:0] RSV_SEL = 2'h3
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [23:0] cfg_in,
    input wire logic routed_in,
    input wire logic [2:0] related_in,
    output logic clk_out,
    output logic reserved_out
);

    // map a select code onto the index of the related input
    function automatic logic [1:0] rel_index(input logic [1:0] sel);
        rel_index = (RSV_SEL == 2'h0) ? 2'(sel - 2'h1) : sel;
    endfunction

    // a code that names no input reads as a quiet low, never as an out-of-range index
    function automatic logic rel_pick(input logic [2:0] clks, input logic [1:0] idx);
        rel_pick = (idx == 2'h3) ? 1'b0 : clks[idx];
    endfunction

    // only the two reserved codes of the map are decoded
    generate
        if (RSV_SEL != 2'h0 && RSV_SEL != 2'h3) begin : g_rsv_check
            $error("RSV_SEL must be 0 or 3");
        end
    endgenerate

    logic [23:0] div_cnt_reg;
    logic [23:0] div_cnt_next;
    logic div_clk_reg;
    logic [15:0] per_cnt_reg;
    logic [15:0] per_cnt_next;
    logic rel_prev_reg;
    logic active_reg;
    logic active_next;
    logic out_reg;

    wire frame_mode = (cfg_in[PFG_MODE_HI:PFG_MODE_LO] == PFG_FRAME_NIBBLE);
    wire [1:0] sel = cfg_in[PFG_SEL_HI:PFG_SEL_LO];
    wire sel_reserved = frame_mode && (sel == RSV_SEL);
    wire [1:0] sel_idx = rel_index(sel);
    wire rel = rel_pick(related_in, sel_idx);
    wire rel_rise = rel && !rel_prev_reg;
    wire rel_fall = !rel && rel_prev_reg;
    wire [15:0] period = cfg_in[PFG_PER_HI:PFG_PER_LO];
    wire period_ok = (period != 16'h0000);
    wire last_period = (per_cnt_reg >= 16'(period - 16'h0001));
    wire edge_type = cfg_in[PFG_TYPE_BIT];
    // configurable pins see the opposite polarity of the programmed bit
    wire invert = cfg_in[PFG_POL_BIT] ^ routed_in;

    // ratios below two cannot be made from one clock edge, so they run at half rate
    wire [23:0] ratio = (cfg_in < PFG_MIN_RATIO) ? PFG_MIN_RATIO : cfg_in;
    wire [23:0] high_len = 24'((25'(ratio) + 25'h1) >> 1);
    wire div_wrap = (div_cnt_reg >= 24'(ratio - 24'h1));

    // ============================================================
    // normal mode divider
    always_comb begin
        div_cnt_next = div_wrap ? 24'h000000 : 24'(div_cnt_reg + 24'h1);
    end

    // ============================================================
    // frame pulse sequencing
    always_comb begin
        per_cnt_next = per_cnt_reg;
        if (rel_rise) begin
            per_cnt_next = last_period ? 16'h0000 : 16'(per_cnt_reg + 16'h0001);
        end
        active_next = active_reg;
        if (!frame_mode || sel_reserved || !period_ok) begin
            active_next = 1'b0;
        end else if (edge_type) begin
            // boundary sits on the rising edge that starts the pulse
            if (rel_rise) begin
                active_next = last_period;
            end
        end else begin
            // pulse opens half a related period before the boundary
            if (rel_fall) begin
                active_next = last_period;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_cnt_reg <= 24'h000000;
            div_clk_reg <= 1'b0;
            per_cnt_reg <= 16'h0000;
            rel_prev_reg <= 1'b0;
            active_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            div_clk_reg <= (div_cnt_next < high_len);
            per_cnt_reg <= per_cnt_next;
            rel_prev_reg <= rel;
            active_reg <= active_next;
            out_reg <= frame_mode ? (active_reg ^ invert) : div_clk_reg;
        end
    end

    assign clk_out = out_reg;
    assign reserved_out = sel_reserved;

    // ============================================================
    // checks
    AST_DIV_HIGH_START: assert property (@(posedge clk_in) disable iff (reset_in)
        (!frame_mode && $stable(cfg_in) && div_wrap) |=> div_clk_reg)
        else $error("divided clock not high at start of period");
    AST_DIV_LOW_HALF: assert property (@(posedge clk_in) disable iff (reset_in)
        (!frame_mode && $stable(cfg_in) && (div_cnt_next >= high_len)) |=> !div_clk_reg)
        else $error("divided clock not low in second half");
    AST_FRAME_IDLE_LEVEL: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && !active_reg) ##1 $stable(cfg_in) && $stable(routed_in) |-> clk_out == invert)
        else $error("idle frame pulse level wrong");
    AST_EDGE_TYPE_START: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && edge_type && !sel_reserved && period_ok && rel_rise && last_period) |=> active_reg)
        else $error("edge type pulse missing at boundary");
    AST_MID_TYPE_START: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && !edge_type && !sel_reserved && period_ok && rel_fall && last_period) |=> active_reg)
        else $error("middle type pulse missing before boundary");
    AST_PERIOD_WRAP: assert property (@(posedge clk_in) disable iff (reset_in)
        (rel_rise && last_period) |=> per_cnt_reg == 16'h0000)
        else $error("period counter failed to wrap");
    AST_RESERVED_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
        sel_reserved [*2] |=> !active_reg && (clk_out == invert))
        else $error("reserved select produced a pulse");
    AST_POLARITY_ROUTE: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && active_reg) ##1 (frame_mode && $stable(cfg_in) && $stable(routed_in))
        |-> clk_out == !(cfg_in[PFG_POL_BIT] ^ routed_in))
        else $error("active pulse level ignores routing");
    AST_NORMAL_OUTPUT: assert property (@(posedge clk_in) disable iff (reset_in)
        !frame_mode |=> clk_out == $past(div_clk_reg))
        else $error("normal mode output does not follow divider");
    AST_FRAME_OUTPUT: assert property (@(posedge clk_in) disable iff (reset_in)
        frame_mode |=> clk_out == $past(active_reg ^ invert))
        else $error("frame mode output does not follow pulse");
    AST_NO_PULSE_QUIET: assert property (@(posedge clk_in) disable iff (reset_in)
        (!frame_mode || sel_reserved || !period_ok) |=> !active_reg)
        else $error("pulse active without a usable setting");

    // period counter moves only on related rising edges
    AST_COUNT_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
        !rel_rise |=> per_cnt_reg == $past(per_cnt_reg))
        else $error("period counter moved without related edge");
    AST_COUNT_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
        (rel_rise && !last_period) |=> per_cnt_reg == 16'($past(per_cnt_reg) + 16'h0001))
        else $error("period counter failed to step");
    AST_EDGE_TYPE_END: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && edge_type && rel_rise && !last_period) |=> !active_reg)
        else $error("edge type pulse wider than one related period");
    AST_MID_TYPE_END: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_mode && !edge_type && rel_fall && !last_period) |=> !active_reg)
        else $error("middle type pulse wider than one related period");

    // divider counter steps by one and wraps to zero
    AST_DIV_WRAP_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        div_wrap |=> div_cnt_reg == 24'h000000)
        else $error("divider counter failed to wrap");
    AST_DIV_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
        !div_wrap |=> div_cnt_reg == 24'($past(div_cnt_reg) + 24'h000001))
        else $error("divider counter failed to step");

endmodule

// ============================================================
// top: register slave and the two channels
module pfg_postdivider_top
    import pfg_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] writedata_in,
    input wire logic [2:0] synth1_related_clk_in,
    input wire logic [2:0] synth2_related_clk_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    output logic synth1_divider_d_clk_out,
    output logic second_synth_first_ratio_clk_out
);

    generate
        if (ADDR_W < 10) begin : g_addr_check
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    logic [23:0] synth1_divider_d_config_reg;
    logic [23:0] synth2_divider_a_config_reg;
    logic [1:0] route_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic d_clk;
    logic a_clk;
    logic d_rsv;
    logic a_rsv;

    // byte lanes 0..2 merge into a 24-bit register; both divider registers share this
    function automatic logic [23:0] merge_lanes(input logic [23:0] old_val, input logic [23:0] new_val,
                                                input logic [23:0] mask);
        merge_lanes = (old_val & ~mask) | (new_val & mask);
    endfunction

    // ============================================================
    // address decode; one wait state gives every access a fixed two-cycle answer
    wire [7:0] index = address_in[9:2];
    wire hit_d = (index == PFG_IDX_S1_DIV_D);
    wire hit_a = (index == PFG_IDX_S2_DIV_A);
    wire hit_route = (index == PFG_IDX_ROUTE);
    wire hit_stat = (index == PFG_IDX_STATUS);
    wire wr_go = write_in && !wait_reg;
    wire [23:0] lane_mask = {{8{byteenable_in[2]}}, {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
    wire [23:0] wdata = writedata_in[23:0];
    wire [23:0] d_wr = merge_lanes(synth1_divider_d_config_reg, wdata, lane_mask);
    wire [23:0] a_wr = merge_lanes(synth2_divider_a_config_reg, wdata, lane_mask);
    wire [3:0] status = {a_rsv, d_rsv, a_clk, d_clk};

    always_comb begin
        rdata_next = PFG_UNMAPPED_DATA;
        if (hit_d) begin
            rdata_next = {8'h00, synth1_divider_d_config_reg};
        end else if (hit_a) begin
            rdata_next = {8'h00, synth2_divider_a_config_reg};
        end else if (hit_route) begin
            rdata_next = {30'h00000000, route_reg};
        end else if (hit_stat) begin
            rdata_next = {28'h0000000, status};
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            synth1_divider_d_config_reg <= PFG_S1_DIV_D_RST;
            synth2_divider_a_config_reg <= PFG_S2_DIV_A_RST;
            route_reg <= PFG_ROUTE_RST;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= !((read_in || write_in) && wait_reg);
            rdata_reg <= (read_in && wait_reg) ? rdata_next : rdata_reg;
            if (wr_go && hit_d) begin
                synth1_divider_d_config_reg <= d_wr;
            end
            if (wr_go && hit_a) begin
                synth2_divider_a_config_reg <= a_wr;
            end
            if (wr_go && hit_route && byteenable_in[0]) begin
                route_reg <= writedata_in[1:0];
            end
        end
    end

    assign readdata_out = rdata_reg;
    assign waitrequest_out = wait_reg;

    // ============================================================
    // channels
    pfg_channel #(
        .RSV_SEL(PFG_S1_RSV_SEL)
    ) u_synth1_d (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .cfg_in(synth1_divider_d_config_reg),
        .routed_in(route_reg[PFG_ROUTE_D_BIT]),
        .related_in(synth1_related_clk_in),
        .clk_out(d_clk),
        .reserved_out(d_rsv)
    );

    pfg_channel #(
        .RSV_SEL(PFG_S2_RSV_SEL)
    ) u_synth2_a (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .cfg_in(synth2_divider_a_config_reg),
        .routed_in(route_reg[PFG_ROUTE_A_BIT]),
        .related_in(synth2_related_clk_in),
        .clk_out(a_clk),
        .reserved_out(a_rsv)
    );

    assign synth1_divider_d_clk_out = d_clk;
    assign second_synth_first_ratio_clk_out = a_clk;

    // ============================================================
    // reset and bus checks
    AST_RESET_VALUE: assert property (@(posedge clk_in)
        reset_in |=> synth1_divider_d_config_reg == PFG_S1_DIV_D_RST)
        else $error("divider D reset value wrong");
    AST_RESET_BUS: assert property (@(posedge clk_in)
        reset_in |=> waitrequest_out && (readdata_out == 32'h00000000))
        else $error("bus outputs not idle after reset");
    AST_RESET_PINS: assert property (@(posedge clk_in)
        reset_in |=> !synth1_divider_d_clk_out && !second_synth_first_ratio_clk_out)
        else $error("clock outputs not low after reset");

    // every request gets exactly one wait state
    AST_WAIT_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (reset_in)
        ((read_in || write_in) && waitrequest_out) |=> !waitrequest_out)
        else $error("request not answered after one wait state");
    AST_WAIT_RELEASE: assert property (@(posedge clk_in) disable iff (reset_in)
        !waitrequest_out |=> waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    AST_WRITE_D: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_go && hit_d) |=> synth1_divider_d_config_reg == $past(d_wr))
        else $error("write to divider D lost");
    AST_WRITE_A: assert property (@(posedge clk_in) disable iff (reset_in)
        (wr_go && hit_a) |=> synth2_divider_a_config_reg == $past(a_wr))
        else $error("write to divider A lost");
    AST_READ_DATA: assert property (@(posedge clk_in) disable iff (reset_in)
        (read_in && waitrequest_out) |=> readdata_out == $past(rdata_next))
        else $error("read answer does not carry the addressed register");

endmodule

// [bench/pfg_related_clk_model.sv]
// far-side model: free-running related post-divider clocks of one synthesizer
`timescale 1ns/1ps
module pfg_related_clk_model (
    input wire logic clk_in,
    input wire logic reset_in,
    output logic [2:0] related_out
);
    // ============================================================
    // periods 4, 6 and 8 cycles; 24 is a common multiple
    logic [4:0] cnt_reg;
    always_ff @(posedge clk_in) begin
        if (reset_in || cnt_reg == 5'h17) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
    // distinct periods let the pulse width show which clock was chosen
    assign related_out[0] = (cnt_reg % 5'h04) < 5'h02;
    assign related_out[1] = (cnt_reg % 5'h06) < 5'h03;
    assign related_out[2] = (cnt_reg % 5'h08) < 5'h04;
endmodule

// [bench/pfg_postdivider_top_tb_top.sv]
// self-checking testbench of the post-divider frame pulse block
`timescale 1ns/1ps
module pfg_postdivider_top_tb_top;
    import pfg_pkg::*;
    // ============================================================
    // signals
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [9:0] address_in = 10'h000;
    logic [3:0] byteenable_in = 4'hF;
    logic [31:0] writedata_in = 32'h00000000;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic d_out;
    logic a_out;
    logic [2:0] rel1;
    logic [2:0] rel2;
    logic sel_ch = 1'b0;
    wire logic obs = sel_ch ? a_out : d_out;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 18;
    int w;
    int p;
    int r;
    logic [31:0] q;

    always #12.5 clk_in = ~clk_in;

    pfg_postdivider_top #(.ADDR_W(10)) dut (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in), .writedata_in(writedata_in),
        .synth1_related_clk_in(rel1), .synth2_related_clk_in(rel2), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .synth1_divider_d_clk_out(d_out),
        .second_synth_first_ratio_clk_out(a_out));
    pfg_related_clk_model far1 (.clk_in(clk_in), .reset_in(reset_in), .related_out(rel1));
    pfg_related_clk_model far2 (.clk_in(clk_in), .reset_in(reset_in), .related_out(rel2));

    // ============================================================
    // expectations and checking
    function automatic int hi_exp(int v);
        return v < 2 ? 1 : (v + 1) / 2;
    endfunction
    function automatic int per_exp(int v);
        return v < 2 ? 2 : v;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // request held until waitrequest is sampled low; no latency assumed
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        read_in <= ~wr;
        write_in <= wr;
        address_in <= {idx, 2'b00};
        writedata_in <= d;
        @(posedge clk_in);
        while (waitrequest_out !== 1'b0 && n < 50) begin
            @(posedge clk_in);
            n++;
        end
        q = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
        end
    endtask

    // width of the lvl phase and full period, taken on the third pulse to skip partial ones
    task automatic measure(input logic ch, input logic lvl);
        int n;
        n = 0;
        sel_ch = ch;
        repeat (2) begin
            w = 0;
            while (obs !== ~lvl && n < 3000) begin @(posedge clk_in); n++; end
            while (obs !== lvl && n < 3000) begin @(posedge clk_in); n++; end
            while (obs === lvl && n < 3000) begin @(posedge clk_in); n++; w++; end
            p = w;
            while (obs !== lvl && n < 3000) begin @(posedge clk_in); n++; p++; end
        end
    endtask

    task automatic frame(input logic ch, input logic [1:0] sel, input logic ty, input logic pol,
                         input logic rt, input int per, input int k);
        bus(1'b1, PFG_IDX_ROUTE, 32'(rt) << ch);
        bus(1'b1, ch ? PFG_IDX_S2_DIV_A : PFG_IDX_S1_DIV_D, {8'h00, PFG_FRAME_NIBBLE, ty, pol, sel, 16'(per)});
        measure(ch, ~(pol ^ rt));
        check(32'(w), 32'(k));
        check(32'(p), 32'(per * k));
    endtask

    task automatic idle_chk(input logic ch, input logic [1:0] sel, input logic pol, input logic rt);
        int bad;
        bad = 0;
        sel_ch = ch;
        bus(1'b1, PFG_IDX_ROUTE, 32'(rt) << ch);
        bus(1'b1, ch ? PFG_IDX_S2_DIV_A : PFG_IDX_S1_DIV_D, {8'h00, PFG_FRAME_NIBBLE, 1'b1, pol, sel, 16'h0003});
        repeat (4) @(posedge clk_in);
        repeat (100) begin
            @(posedge clk_in);
            if (obs !== (pol ^ rt)) begin bad++; end
        end
        check(32'(bad), 32'h00000000);
        bus(1'b0, PFG_IDX_ROUTE, 32'h00000000);
        check(q, 32'(rt) << ch);
        bus(1'b0, PFG_IDX_STATUS, 32'h00000000);
        check(32'(q[2 + ch]), 32'h00000001);
        check(32'(q[ch]), 32'(pol ^ rt));
    endtask

    // ============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        bus(1'b0, PFG_IDX_S1_DIV_D, 32'h00000000);
        check(q, 32'(PFG_S1_DIV_D_RST));
        bus(1'b0, PFG_IDX_S2_DIV_A, 32'h00000000);
        check(q, 32'(PFG_S2_DIV_A_RST));
        bus(1'b1, 8'h10, 32'h00FFFFFF);
        bus(1'b0, 8'h10, 32'h00000000);
        check(q, PFG_UNMAPPED_DATA);
        measure(1'b0, 1'b1);
        check(32'(w), 32'(hi_exp(50)));
        check(32'(p), 32'h00000032);
        for (int i = 0; i < 8; i++) begin
            // ratios kept far below the normal-mode maximum
            r = (i == 0) ? 1 : (i == 1) ? 3 : 2 + ($random(seed) & 32'h1F);
            bus(1'b1, i[0] ? PFG_IDX_S1_DIV_D : PFG_IDX_S2_DIV_A, 32'(r));
            bus(1'b0, i[0] ? PFG_IDX_S1_DIV_D : PFG_IDX_S2_DIV_A, 32'h00000000);
            check(q, 32'(r));
            measure(i[0] ? 1'b0 : 1'b1, 1'b1);
            check(32'(w), 32'(hi_exp(r)));
            check(32'(p), 32'(per_exp(r)));
        end
        // related clock is never the channel itself; the model has no such output
        for (int i = 0; i < 3; i++) begin
            frame(1'b0, i[1:0], i[0], i[1], i == 2, 2 + ($random(seed) & 32'h3), 4 + 2 * i);
        end
        for (int i = 1; i < 4; i++) begin
            frame(1'b1, i[1:0], $random(seed) & 1, i[0], ~i[1], 2 + ($random(seed) & 32'h3), 2 + 2 * i);
        end
        idle_chk(1'b0, PFG_S1_RSV_SEL, 1'b1, 1'b0);
        idle_chk(1'b1, PFG_S2_RSV_SEL, 1'b0, 1'b1);
        wrap_up();
    end

    initial begin
        #(25 * 40000);
        n_mismatch++;
        wrap_up();
    end
endmodule
